// ---- common/lvd_pkg.sv ----
package lvd_pkg;
    // ------------------------------------------------------------
    // bus transfer kinds and delay state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {HT_IDLE = 2'h0, HT_BUSY = 2'h1, HT_NONSEQ = 2'h2,
                              HT_SEQ = 2'h3} htrans_type;
    typedef enum {DLY_IDLE, DLY_RUN, DLY_DONE} delay_state_type;
endpackage : lvd_pkg

// ---- common/lvd_regs.svh ----
// Notes on behaviour
// - three-bit code picks one of eight levels
// - code zero compares external pin, else supply
// - flag reads one while voltage below level
// - enable bit powers detector on or off
// - enable also turns reference on automatically
// - sleep forces detector off despite enable
// - request feeds shared multi-function interrupt
// - request raised after interrupt delay, or preset by a write to the delay offset
// - idle-mode low voltage sets request, wakes unless request already set
`ifndef LVD_REGS_SVH
`define LVD_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LVD_CTRL_OFS        12'h000
`define LVD_IRQ_STATUS_OFS  12'h004
`define LVD_IRQ_MASK_OFS    12'h008
`define LVD_DELAY_OFS       12'h00c

// ----------------------------------------------------------------
// control field positions and reset values
// ----------------------------------------------------------------
`define LVD_THR_LSB         0
`define LVD_REFBUF_BIT      3
`define LVD_EN_BIT          4
`define LVD_FLAG_BIT        5
`define LVD_CTRL_RESET      8'h00
`define LVD_WR_MASK         8'h1f
`define LVD_THR_EXT_PIN     3'h0

// ----------------------------------------------------------------
// timing: interrupt delay in ns and cycles at 200 MHz
// ----------------------------------------------------------------
`define LVD_CLK_NS          5
`define LVD_IRQ_DELAY_NS    15000
`define LVD_IRQ_DELAY_CYC   ((`LVD_IRQ_DELAY_NS + `LVD_CLK_NS - 1) / `LVD_CLK_NS)
`define LVD_STAB_DELAY_NS   15000

`endif

// ---- hdl/lvd_delay.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// qualifies the raw flag: fires once after it stays high a delay
// ----------------------------------------------------------------
module lvd_delay #(
    parameter int CYCLES = 3000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // flag in, event out
    input  wire logic level,
    output logic      fire
);
    initial begin
        if (CYCLES < 1 || CYCLES > 65535) $error("lvd_delay: CYCLES out of range");
    end

    lvd_pkg::delay_state_type state_q;   // delay state
    logic [15:0]              cnt_q;     // elapsed cycles

    // state and counter; low level restarts the wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= lvd_pkg::DLY_IDLE;
            cnt_q   <= 16'h0000;
            fire    <= 1'b0;
        end else begin
            fire <= 1'b0;
            case (state_q)
                lvd_pkg::DLY_IDLE: begin
                    cnt_q <= 16'h0001;
                    if (level) state_q <= lvd_pkg::DLY_RUN;
                end
                lvd_pkg::DLY_RUN: begin
                    if (!level) begin
                        state_q <= lvd_pkg::DLY_IDLE;        // glitch: drop it
                    end else if (cnt_q >= 16'(CYCLES)) begin
                        fire    <= 1'b1;
                        state_q <= lvd_pkg::DLY_DONE;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                default: begin
                    if (!level) state_q <= lvd_pkg::DLY_IDLE; // rearm on fall
                end
            endcase
        end
    end
endmodule : lvd_delay

// ---- hdl/lvd_top.sv ----
`timescale 1ns/10ps
`include "lvd_regs.svh"
// ----------------------------------------------------------------
// low voltage detector control, AHB-Lite slave
// ----------------------------------------------------------------
module lvd_top #(
    parameter int IRQ_DELAY_CYC = `LVD_IRQ_DELAY_CYC
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [11:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // analog comparator side
    input  wire logic        CMP_BELOW,
    output logic             DET_POWER,
    output logic             REF_ENABLE,
    output logic             REFBUF_ENABLE,
    output logic [2:0]       THRESHOLD_SELECT,
    output logic             USE_EXT_INPUT,
    // power state
    input  wire logic        SLEEP_MODE,
    input  wire logic        IDLE_MODE,
    // interrupt and wake
    output logic             IRQ,
    output logic             WAKE
);
    initial begin
        if (IRQ_DELAY_CYC < 1 || IRQ_DELAY_CYC > 65535) $error("lvd_top: bad IRQ_DELAY_CYC");
    end

    // ------------------------------------------------------------
    // reset release through two flops
    // ------------------------------------------------------------
    logic rst_s1_q;   // first stage
    logic rst_n;      // synchronised reset

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0]  thr_q;        // threshold code
    logic        refbuf_q;     // reference buffer enable
    logic        en_q;         // detector enable
    logic        flag_q;       // low voltage flag
    logic        req_q;        // detector irq request, sticky
    logic        mask_q;       // interrupt enable
    logic        wr_pend_q;    // write data phase pending
    logic [11:0] addr_q;       // latched address
    logic        fire;         // qualified low event
    logic        active;       // detector really powered
    logic [31:0] rdata_d;      // read mux
    logic        take;         // address phase accepted

    // sleep overrides the enable bit
    assign active = en_q && !SLEEP_MODE;
    assign take   = HSEL && HREADY && HTRANS[1];

    // ------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end else if (HREADY) begin
            wr_pend_q <= take && HWRITE;
            addr_q    <= HADDR;
        end
    end

    // ------------------------------------------------------------
    // control register writes; flag and upper bits never written
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            thr_q    <= 3'h0;
            refbuf_q <= 1'b0;
            en_q     <= 1'b0;
        end else if (wr_pend_q && addr_q == `LVD_CTRL_OFS) begin
            thr_q    <= HWDATA[`LVD_THR_LSB +: 3];
            refbuf_q <= HWDATA[`LVD_REFBUF_BIT];
            en_q     <= HWDATA[`LVD_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // flag follows the comparator while powered
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            // the comparator output is garbage until power has reached it,
            // so the flag also waits for the registered power line
            flag_q <= active && DET_POWER && CMP_BELOW;
        end
    end

    lvd_delay #(
        .CYCLES (IRQ_DELAY_CYC)
    ) u_delay (
        .clk   (CLK),
        .rst_n (rst_n),
        .level (flag_q),
        .fire  (fire)
    );

    // ------------------------------------------------------------
    // sticky request; set beats write-one-clear; software may set it
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            req_q  <= 1'b0;
            mask_q <= 1'b0;
        end else begin
            if (fire) begin
                req_q <= 1'b1;
            end else if (wr_pend_q && addr_q == `LVD_IRQ_STATUS_OFS) begin
                req_q <= req_q & ~HWDATA[0];                 // write one clears
            end else if (wr_pend_q && addr_q == `LVD_DELAY_OFS) begin
                req_q <= req_q | HWDATA[0];                  // preset
            end
            if (wr_pend_q && addr_q == `LVD_IRQ_MASK_OFS) begin
                mask_q <= HWDATA[0];
            end
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;   // unmapped reads zero
        if (HADDR == `LVD_CTRL_OFS) begin
            rdata_d[7:0] = {2'b00, flag_q, en_q, refbuf_q, thr_q};
        end else if (HADDR == `LVD_IRQ_STATUS_OFS) begin
            rdata_d[0] = req_q;
        end else if (HADDR == `LVD_IRQ_MASK_OFS) begin
            rdata_d[0] = mask_q;
        end else if (HADDR == `LVD_DELAY_OFS) begin
            rdata_d[0] = req_q;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            HRDATA           <= 32'h0000_0000;
            HREADYOUT        <= 1'b1;
            HRESP            <= 1'b0;
            DET_POWER        <= 1'b0;
            REF_ENABLE       <= 1'b0;
            REFBUF_ENABLE    <= 1'b0;
            THRESHOLD_SELECT <= 3'h0;
            USE_EXT_INPUT    <= 1'b1;
            IRQ              <= 1'b0;
            WAKE             <= 1'b0;
        end else begin
            HREADYOUT        <= 1'b1;                   // zero wait states
            HRESP            <= 1'b0;
            if (take && !HWRITE) HRDATA <= rdata_d;
            DET_POWER        <= active;
            REF_ENABLE       <= active;
            REFBUF_ENABLE    <= refbuf_q;
            THRESHOLD_SELECT <= thr_q;
            USE_EXT_INPUT    <= thr_q == `LVD_THR_EXT_PIN;
            IRQ              <= req_q && mask_q;
            // wake comes from the request rising; a preset request blocks it
            WAKE             <= fire && IDLE_MODE && !req_q;
        end
    end
endmodule : lvd_top

// ---- tb/lvd_analog_model.sv ----
`timescale 1ns/10ps
// --------------------
// comparator and reference model
// --------------------
module lvd_analog_model (
    // clock
    input  wire logic       clk,
    // control from the block
    input  wire logic       powered,
    input  wire logic [2:0] sel,
    input  wire logic       use_ext,
    // test voltages: supply as level index, pin as flag
    input  wire logic [2:0] vdd_lvl,
    input  wire logic       ext_low,
    // comparator result
    output logic            below
);
    logic junk_q = 1'b0; // unpowered output, never steady
    // toggles so an unpowered result cannot pass for a real one
    always_ff @(posedge clk) begin
        junk_q <= ~junk_q;
    end
    // compare against the chosen level
    always_comb begin
        if (!powered) begin
            below = junk_q;
        end else if (use_ext) begin
            below = ext_low;
        end else begin
            below = (vdd_lvl < sel);
        end
    end
endmodule : lvd_analog_model

// ---- tb/lvd_top_sva.sv ----
`timescale 1ns/10ps
`include "lvd_regs.svh"
// --------------------
// port checks of the detector block
// --------------------
module lvd_top_sva #(
    parameter int IRQ_DELAY_CYC = 4
) (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RSTN,
    // bus request
    input wire logic        HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    // analog side and power state
    input wire logic        CMP_BELOW,
    input wire logic        DET_POWER,
    input wire logic        REF_ENABLE,
    input wire logic        REFBUF_ENABLE,
    input wire logic [2:0]  THRESHOLD_SELECT,
    input wire logic        USE_EXT_INPUT,
    input wire logic        SLEEP_MODE,
    input wire logic        IDLE_MODE,
    input wire logic        WAKE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // address phase of a control write
    sequence ctrl_write;
        HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == `LVD_CTRL_OFS;
    endsequence
    // comparator below at both ends of the qualifying delay
    sequence held_low;
        $past(CMP_BELOW, 3) && $past(CMP_BELOW, IRQ_DELAY_CYC + 3);
    endsequence
    a_ref_tracks_power: assert property (REF_ENABLE == DET_POWER)
        else $error("reference enable differs from detector power");
    a_sleep_forces_off: assert property (SLEEP_MODE |=> !DET_POWER)
        else $error("detector powered in sleep");
    a_ext_on_zero: assert property (USE_EXT_INPUT == (THRESHOLD_SELECT == 3'h0))
        else $error("pin select does not follow code zero");
    a_ctrl_write_lands: assert property (ctrl_write |-> ##3
        (THRESHOLD_SELECT == $past(HWDATA[2:0], 2) && REFBUF_ENABLE == $past(HWDATA[3], 2)))
        else $error("control write not applied");
    a_wake_after_delay: assert property (WAKE |-> held_low)
        else $error("wake without held low voltage");
    a_wake_one_cycle: assert property (WAKE |=> !WAKE)
        else $error("wake longer than one cycle");
    a_wake_needs_idle: assert property (WAKE |-> $past(IDLE_MODE))
        else $error("wake outside idle");
    a_power_rise: assert property ($rose(DET_POWER) |-> !$past(SLEEP_MODE))
        else $error("detector powered up during sleep");
endmodule : lvd_top_sva

// ---- tb/test_lvd_top.sv ----
`timescale 1ns/10ps
`include "lvd_regs.svh"
// --------------------
// bench of the detector block
// --------------------
module test_lvd_top;
    localparam int DLY = 4; // short delay keeps the run brief
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        sleep = 1'b0, idle = 1'b0, ext_low = 1'b1;
    logic [1:0]  htrans = 2'h0;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic [2:0]  vdd_lvl = 3'h7, thr; // supply level index, select
    logic        hready, hresp, below, pwr, ref_en, refbuf, ext_sel, irq, wake;
    int          fail_count = 0, n_compared = 0;
    lvd_top #(.IRQ_DELAY_CYC(DLY)) DUT (.CLK(clk), .RSTN(rst_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .CMP_BELOW(below), .DET_POWER(pwr), .REF_ENABLE(ref_en),
        .REFBUF_ENABLE(refbuf), .THRESHOLD_SELECT(thr), .USE_EXT_INPUT(ext_sel),
        .SLEEP_MODE(sleep), .IDLE_MODE(idle), .IRQ(irq), .WAKE(wake));
    lvd_analog_model cmp (.clk(clk), .powered(pwr && ref_en), .sel(thr),
        .use_ext(ext_sel), .vdd_lvl(vdd_lvl), .ext_low(ext_low), .below(below));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // waits for a high level on irq or wake, bounded
    task automatic wait_hi(input logic which, output int n);
        n = 0;
        while ((which ? wake : irq) !== 1'b1 || n == 0) begin
            @(posedge clk);
            n++;
            if (n > 80) begin
                fail_count++;
                $display("unexpected at %0t: wait ran out", $time);
                wrap_up;
            end
        end
    endtask : wait_hi
    // one edge at which ready is high
    task automatic edge_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 50) begin
                fail_count++;
                $display("unexpected at %0t: bus hang", $time);
                wrap_up;
            end
        end
    endtask : edge_rdy
    // single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= lvd_pkg::HT_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        edge_rdy;
        htrans <= lvd_pkg::HT_IDLE;
        hsel <= 1'b0;
        hwdata <= d;
        edge_rdy;
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask : bus
    task automatic t_regs;
        bus(1'b0, `LVD_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `LVD_CTRL_OFS, 32'hff);
        bus(1'b0, `LVD_CTRL_OFS, 32'h0);
        chk(rd, 32'h1f);
        chk({pwr, ref_en, refbuf, thr}, 32'h3f);
        bus(1'b1, `LVD_CTRL_OFS, 32'h0f);
        repeat (2) @(posedge clk);
        chk(pwr, 1'b0);
    endtask : t_regs
    // every code: pin on code zero, supply level else
    task automatic t_thresh;
        vdd_lvl <= 3'h3;
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, `LVD_CTRL_OFS, 32'h10 | c);
            repeat (3) @(posedge clk);
            bus(1'b0, `LVD_CTRL_OFS, 32'h0);
            chk(rd[5], (c == 0) ? 1'b1 : (3 < c));
            chk(ext_sel, c == 0);
        end
    endtask : t_thresh
    task automatic t_irq;
        int n;
        vdd_lvl <= 3'h7;
        bus(1'b1, `LVD_CTRL_OFS, 32'h17);
        bus(1'b1, `LVD_IRQ_STATUS_OFS, 32'h1);
        bus(1'b1, `LVD_IRQ_MASK_OFS, 32'h1);
        bus(1'b0, `LVD_IRQ_STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        // supply chatters around the level: short dips must not raise a request
        repeat (6) begin
            vdd_lvl <= 3'h0;
            repeat (2) @(posedge clk);
            vdd_lvl <= 3'h7;
            repeat (2) @(posedge clk);
        end
        bus(1'b0, `LVD_IRQ_STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        vdd_lvl <= 3'h0;
        wait_hi(1'b0, n);
        chk(n > DLY, 1'b1);
        bus(1'b0, `LVD_IRQ_STATUS_OFS, 32'h0);
        chk(rd, 32'h1);
        bus(1'b1, `LVD_IRQ_MASK_OFS, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        vdd_lvl <= 3'h7;
        bus(1'b1, `LVD_IRQ_STATUS_OFS, 32'h1);
        bus(1'b0, `LVD_IRQ_STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
    endtask : t_irq
    task automatic t_sleep;
        sleep <= 1'b1;
        repeat (2) @(posedge clk);
        chk({pwr, ref_en}, 2'h0);
        sleep <= 1'b0;
        repeat (2) @(posedge clk);
        chk(pwr, 1'b1);
    endtask : t_sleep
    task automatic t_wake;
        int n;
        idle <= 1'b1;
        vdd_lvl <= 3'h0;
        wait_hi(1'b1, n);
        chk(n > DLY, 1'b1);
        vdd_lvl <= 3'h7;
        bus(1'b1, `LVD_IRQ_STATUS_OFS, 32'h1);
        bus(1'b1, `LVD_DELAY_OFS, 32'h1);
        bus(1'b0, `LVD_IRQ_STATUS_OFS, 32'h0);
        chk(rd, 32'h1);
        vdd_lvl <= 3'h0;
        n = 0;
        repeat (20) begin
            @(posedge clk);
            if (wake !== 1'b0) n++;
        end
        chk(n, 0);
        idle <= 1'b0;
    endtask : t_wake
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_thresh;
        t_irq;
        t_sleep;
        t_wake;
        wrap_up;
    end
endmodule : test_lvd_top
bind lvd_top lvd_top_sva #(.IRQ_DELAY_CYC(IRQ_DELAY_CYC)) u_sva (.CLK(CLK), .RSTN(RSTN),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
    .HREADY(HREADY), .CMP_BELOW(CMP_BELOW), .DET_POWER(DET_POWER),
    .REF_ENABLE(REF_ENABLE), .REFBUF_ENABLE(REFBUF_ENABLE), .WAKE(WAKE),
    .THRESHOLD_SELECT(THRESHOLD_SELECT), .USE_EXT_INPUT(USE_EXT_INPUT),
    .SLEEP_MODE(SLEEP_MODE), .IDLE_MODE(IDLE_MODE));
